// ===== hdl/rx_ctrl_defines.svh
// Constants of the receive control and status block
// Function
// - Single-receive enable sits at bit 5 of the receive status/control register.
// - Sync master mode: single-receive set starts one reception; clear means none.
// - Sync master mode: hardware clears single-receive once that reception completes.
// - Single-receive is ignored in asynchronous and synchronous slave modes.
// - Async mode: continuous-receive at bit 4 enables receiver, clear disables it.
// - Sync mode: continuous-receive receives continuously and overrides single-receive.
// - Async 9-bit with address detect: load buffer and interrupt only if ninth bit 1.
// - Async 9-bit without address detect: accept all bytes, ninth bit free for software.
// - Async 8-bit mode ignores the address detect control.
// - Framing error flag at bit 2, updated by buffer read plus next valid byte.
// - Overrun flag at bit 1; clearing continuous-receive clears it.
// - Ninth received data bit shows at bit 0 of the status/control register.
`ifndef RX_CTRL_DEFINES_SVH
`define RX_CTRL_DEFINES_SVH

`define RX_ADDR_W 3
`define RX_OFS_STATUS_CONTROL 3'h0
`define RX_OFS_BUFFER 3'h1
`define RX_OFS_MODE 3'h2
`define RX_OFS_IRQ_STATUS 3'h3
`define RX_OFS_IRQ_MASK 3'h4

`define RX_BIT_SINGLE 5
`define RX_BIT_CONT 4
`define RX_BIT_ADDR 3
`define RX_BIT_FRAMING_ERROR_FLAG 2
`define RX_BIT_OVERRUN_ERROR_FLAG 1
`define RX_BIT_NINTH 0

`define RX_MODE_BIT_SYNC 0
`define RX_MODE_BIT_MASTER 1
`define RX_MODE_BIT_NINE 2

`define RX_IRQ_BIT_RECV 0
`define RX_IRQ_BIT_FRAMING_ERROR_FLAG 1
`define RX_IRQ_BIT_OVERRUN_ERROR_FLAG 2
`define RX_IRQ_W 3

`define RX_RST_CTRL 3'h0
`define RX_RST_MODE 3'h0
`define RX_RST_MASK 3'h0

`endif

// ===== hdl/rx_ctrl_pkg.sv
// Types of the receive control and status block
package rx_ctrl_pkg;

  // Gray coded operating modes
  typedef enum logic [1:0] {
    MODE_ASYNC = 2'h0,
    MODE_SYNC_MASTER = 2'h1,
    MODE_SYNC_SLAVE = 2'h3
  } rx_mode_e;

  typedef logic [7:0] byte_t;

endpackage

// ===== hdl/rx_irq_sticky.sv
// Sticky event status with mask and level interrupt
`timescale 1ns/1ps
`default_nettype none
module rx_irq_sticky #(
  parameter int W = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Events and software access
  input wire logic [W-1:0] event_pulse,
  input wire logic status_read,
  input wire logic [W-1:0] mask,
  // State
  output logic [W-1:0] status,
  output logic irq
);
  logic [W-1:0] status_q;
  logic [W-1:0] status_d;
  logic irq_q;
  logic irq_d;

  // A new event in the reading cycle survives the clear
  always_comb begin
    status_d = status_read ? event_pulse : (status_q | event_pulse);
    irq_d = |(status_d & mask);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_q <= '0;
      irq_q <= 1'b0;
    end else begin
      status_q <= status_d;
      irq_q <= irq_d;
    end
  end

  assign status = status_q;
  assign irq = irq_q;
endmodule // rx_irq_sticky
`default_nettype wire

// ===== hdl/rx_ctrl.sv
// Receive control and status logic with register port
`timescale 1ns/1ps
`default_nettype none
`include "rx_ctrl_defines.svh"
module rx_ctrl
  import rx_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [`RX_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Receive shift register side
  input wire logic word_done,
  input wire logic [8:0] receive_shift_register,
  input wire logic word_framing_error,
  // Receiver control toward the shifter
  output logic receiver_enable,
  output logic single_active,
  output logic buffer_full,
  // Interrupt
  output logic irq
);
  // Control and status
  logic single_receive_en_q, single_receive_en_d;
  logic continuous_receive_en_q, continuous_receive_en_d;
  logic address_detect_en_q, address_detect_en_d;
  logic overrun_error_flag_q, overrun_error_flag_d;
  logic sync_mode_q, sync_mode_d;
  logic master_q, master_d;
  logic nine_bit_receive_select_q, nine_bit_receive_select_d;
  logic [`RX_IRQ_W-1:0] irq_mask_q, irq_mask_d;
  // One-entry receive buffer
  byte_t receive_buffer_q, receive_buffer_d;
  logic rx_ninth_data_bit_q, rx_ninth_data_bit_d;
  logic framing_error_flag_q, framing_error_flag_d;
  logic full_q, full_d;
  // Outputs
  logic [7:0] rdata_q, rdata_d;
  logic recv_en_q, recv_en_d;
  logic single_q, single_d;

  rx_mode_e mode;
  logic wr_ctrl, wr_mode, wr_mask;
  logic rd_buf, rd_irq;
  logic accept, load, overrun;
  logic [`RX_IRQ_W-1:0] events;
  logic [`RX_IRQ_W-1:0] irq_status;
  logic [7:0] ctrl_view;

  always_comb begin
    if (!sync_mode_q) begin
      mode = MODE_ASYNC;
    end else if (master_q) begin
      mode = MODE_SYNC_MASTER;
    end else begin
      mode = MODE_SYNC_SLAVE;
    end
  end

  assign wr_ctrl = reg_wr && (reg_addr == `RX_OFS_STATUS_CONTROL);
  assign wr_mode = reg_wr && (reg_addr == `RX_OFS_MODE);
  assign wr_mask = reg_wr && (reg_addr == `RX_OFS_IRQ_MASK);
  assign rd_buf = reg_rd && (reg_addr == `RX_OFS_BUFFER);
  assign rd_irq = reg_rd && (reg_addr == `RX_OFS_IRQ_STATUS);

  // Address filtering only applies to asynchronous nine-bit frames
  always_comb begin
    accept = 1'b1;
    if (mode == MODE_ASYNC && nine_bit_receive_select_q && address_detect_en_q) begin
      accept = receive_shift_register[8];
    end
  end

  // Buffer frees on the read, so a word landing in the read cycle still fits
  assign overrun = word_done && recv_en_q && accept && full_q && !rd_buf && !overrun_error_flag_q;
  assign load = word_done && recv_en_q && accept && !overrun_error_flag_q && !overrun;

  assign events[`RX_IRQ_BIT_RECV] = load;
  assign events[`RX_IRQ_BIT_FRAMING_ERROR_FLAG] = load && word_framing_error;
  assign events[`RX_IRQ_BIT_OVERRUN_ERROR_FLAG] = overrun;

  always_comb begin
    ctrl_view = 8'h00;
    ctrl_view[`RX_BIT_SINGLE] = single_receive_en_q;
    ctrl_view[`RX_BIT_CONT] = continuous_receive_en_q;
    ctrl_view[`RX_BIT_ADDR] = address_detect_en_q;
    ctrl_view[`RX_BIT_FRAMING_ERROR_FLAG] = framing_error_flag_q;
    ctrl_view[`RX_BIT_OVERRUN_ERROR_FLAG] = overrun_error_flag_q;
    ctrl_view[`RX_BIT_NINTH] = rx_ninth_data_bit_q;
  end

  // Next state of control, buffer and outputs
  always_comb begin
    single_receive_en_d = single_receive_en_q;
    continuous_receive_en_d = continuous_receive_en_q;
    address_detect_en_d = address_detect_en_q;
    overrun_error_flag_d = overrun_error_flag_q;
    sync_mode_d = sync_mode_q;
    master_d = master_q;
    nine_bit_receive_select_d = nine_bit_receive_select_q;
    irq_mask_d = irq_mask_q;
    receive_buffer_d = receive_buffer_q;
    rx_ninth_data_bit_d = rx_ninth_data_bit_q;
    framing_error_flag_d = framing_error_flag_q;
    full_d = full_q;
    rdata_d = 8'h00;

    if (wr_ctrl) begin
      single_receive_en_d = reg_wdata[`RX_BIT_SINGLE];
      continuous_receive_en_d = reg_wdata[`RX_BIT_CONT];
      address_detect_en_d = reg_wdata[`RX_BIT_ADDR];
      if (!reg_wdata[`RX_BIT_CONT]) begin
        overrun_error_flag_d = 1'b0;
      end
    end
    if (wr_mode) begin
      sync_mode_d = reg_wdata[`RX_MODE_BIT_SYNC];
      master_d = reg_wdata[`RX_MODE_BIT_MASTER];
      nine_bit_receive_select_d = reg_wdata[`RX_MODE_BIT_NINE];
    end
    if (wr_mask) begin
      irq_mask_d = reg_wdata[`RX_IRQ_W-1:0];
    end

    // Completed single reception clears the request, even against a write
    if (word_done && recv_en_q && mode == MODE_SYNC_MASTER && single_receive_en_q &&
        !continuous_receive_en_q) begin
      single_receive_en_d = 1'b0;
    end

    if (overrun) begin
      overrun_error_flag_d = 1'b1;
    end

    if (rd_buf) begin
      full_d = 1'b0;
    end
    // Flags of the held word change only when the next word is loaded
    if (load) begin
      receive_buffer_d = receive_shift_register[7:0];
      rx_ninth_data_bit_d = receive_shift_register[8];
      framing_error_flag_d = word_framing_error;
      full_d = 1'b1;
    end

    if (reg_rd) begin
      case (reg_addr)
        `RX_OFS_STATUS_CONTROL: rdata_d = ctrl_view;
        `RX_OFS_BUFFER: rdata_d = receive_buffer_q;
        `RX_OFS_MODE: begin
          rdata_d[`RX_MODE_BIT_SYNC] = sync_mode_q;
          rdata_d[`RX_MODE_BIT_MASTER] = master_q;
          rdata_d[`RX_MODE_BIT_NINE] = nine_bit_receive_select_q;
        end
        `RX_OFS_IRQ_STATUS: rdata_d = {5'h00, irq_status};
        `RX_OFS_IRQ_MASK: rdata_d = {5'h00, irq_mask_q};
        default: rdata_d = 8'h00;
      endcase
    end

    // Receiver enable per mode, from the next control values
    recv_en_d = 1'b0;
    single_d = 1'b0;
    case (mode)
      MODE_ASYNC: recv_en_d = continuous_receive_en_d;
      MODE_SYNC_MASTER: begin
        recv_en_d = continuous_receive_en_d || single_receive_en_d;
        single_d = single_receive_en_d && !continuous_receive_en_d;
      end
      MODE_SYNC_SLAVE: recv_en_d = continuous_receive_en_d;
      default: recv_en_d = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      single_receive_en_q <= 1'b0;
      continuous_receive_en_q <= 1'b0;
      address_detect_en_q <= 1'b0;
      overrun_error_flag_q <= 1'b0;
      sync_mode_q <= 1'b0;
      master_q <= 1'b0;
      nine_bit_receive_select_q <= 1'b0;
      irq_mask_q <= `RX_RST_MASK;
      receive_buffer_q <= 8'h00;
      rx_ninth_data_bit_q <= 1'b0;
      framing_error_flag_q <= 1'b0;
      full_q <= 1'b0;
      rdata_q <= 8'h00;
      recv_en_q <= 1'b0;
      single_q <= 1'b0;
    end else begin
      single_receive_en_q <= single_receive_en_d;
      continuous_receive_en_q <= continuous_receive_en_d;
      address_detect_en_q <= address_detect_en_d;
      overrun_error_flag_q <= overrun_error_flag_d;
      sync_mode_q <= sync_mode_d;
      master_q <= master_d;
      nine_bit_receive_select_q <= nine_bit_receive_select_d;
      irq_mask_q <= irq_mask_d;
      receive_buffer_q <= receive_buffer_d;
      rx_ninth_data_bit_q <= rx_ninth_data_bit_d;
      framing_error_flag_q <= framing_error_flag_d;
      full_q <= full_d;
      rdata_q <= rdata_d;
      recv_en_q <= recv_en_d;
      single_q <= single_d;
    end
  end

  rx_irq_sticky #(
    .W(`RX_IRQ_W)
  ) u_irq (
    .clk(clk),
    .rst(rst),
    .event_pulse(events),
    .status_read(rd_irq),
    .mask(irq_mask_q),
    .status(irq_status),
    .irq(irq)
  );

  assign reg_rdata = rdata_q;
  assign receiver_enable = recv_en_q;
  assign single_active = single_q;
  assign buffer_full = full_q;
endmodule // rx_ctrl
`default_nettype wire

// ===== bench/serial_peer.sv
// Far-side transmitter model handing finished words to the receiver
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
  // Clock, reset and command
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic [8:0] word,
  input wire logic bad_stop,
  // Finished word
  output logic word_done,
  output logic [8:0] receive_shift_register,
  output logic word_framing_error
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      word_done <= 1'b0;
      receive_shift_register <= 9'h000;
      word_framing_error <= 1'b0;
    end else if (go) begin
      word_done <= 1'b1;
      receive_shift_register <= word;
      word_framing_error <= bad_stop;
    end else begin
      // Stale word flips so it can never pass for a fresh one
      word_done <= 1'b0;
      receive_shift_register <= ~receive_shift_register;
      word_framing_error <= ~word_framing_error;
    end
  end
endmodule // serial_peer
`default_nettype wire

// ===== bench/rx_ctrl_assertions.sv
// Port assertions of the receive control block
`timescale 1ns/1ps
`default_nettype none
`include "rx_ctrl_defines.svh"
module rx_ctrl_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [`RX_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Word side and outputs
  input wire logic word_done,
  input wire logic [8:0] receive_shift_register,
  input wire logic word_framing_error,
  input wire logic receiver_enable,
  input wire logic single_active,
  input wire logic buffer_full,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  idle_rdata_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero");
  ctrl_reserved_a: assert property ($past(reg_rd) && $past(reg_addr) == 3'h0
    |-> reg_rdata[7:6] == 2'h0) else $error("reserved bits set");
  buffer_fill_a: assert property ($rose(buffer_full)
    |-> $past(word_done) && $past(receiver_enable)) else $error("buffer filled unasked");
  buffer_drain_a: assert property (reg_rd && reg_addr == 3'h1 && !word_done
    |=> !buffer_full) else $error("buffer still full");
  single_clear_a: assert property (single_active && word_done |=> !single_active)
    else $error("single receive not cleared");
  single_start_a: assert property ($rose(single_active)
    |-> $past(reg_wr) || $past(reg_wr, 2)) else $error("single receive rose alone");
  enable_cause_a: assert property ($changed(receiver_enable) |-> $past(reg_wr)
    || $past(reg_wr, 2) || $past(word_done) || $past(word_done, 2)) else $error("enable moved");
  overrun_clear_a: assert property ((reg_wr && reg_addr == 3'h0 && !reg_wdata[4]
    && !word_done) ##1 !word_done ##1 (reg_rd && reg_addr == 3'h0 && !word_done)
    |=> !reg_rdata[1]) else $error("overrun flag kept");
  // A mask write reaches the level output one cycle later than a loaded word
  irq_cause_a: assert property ($rose(irq) |-> $past(word_done) || $past(reg_wr, 2))
    else $error("interrupt rose alone");
endmodule // rx_ctrl_checker
bind rx_ctrl rx_ctrl_checker checker_i (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .word_done, .receive_shift_register, .word_framing_error, .receiver_enable,
  .single_active, .buffer_full, .irq);
`default_nettype wire

// ===== bench/serial_receive_control_status_bench.sv
// Self-checking bench for the receive control and status block
`timescale 1ns/1ps
`default_nettype none
`include "rx_ctrl_defines.svh"
module serial_receive_control_status_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [`RX_ADDR_W-1:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic go = 1'b0;
  logic bad_stop = 1'b0;
  logic [8:0] word = 9'h000;
  logic [8:0] receive_shift_register;
  logic [7:0] reg_rdata;
  logic word_done, word_framing_error, receiver_enable, single_active, buffer_full, irq;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  always #10 clk = ~clk;
  serial_peer peer (.clk, .rst, .go, .word, .bad_stop, .word_done, .receive_shift_register,
    .word_framing_error);
  rx_ctrl uut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .word_done,
    .receive_shift_register, .word_framing_error, .receiver_enable, .single_active,
    .buffer_full, .irq);
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // The whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      results();
    end
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One register access; a read compares the data of the following cycle
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 if (!w) chk("rdata", reg_rdata, d);
  endtask
  // Outputs packed as enable, irq, single, full; 8'hFF skips the look
  task automatic send(input logic [8:0] w, input logic f, input logic [7:0] e);
    @(posedge clk);
    go <= 1'b1;
    word <= w;
    bad_stop <= f;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
    #1 if (e != 8'hFF) chk("outputs", {4'h0, receiver_enable, irq, single_active, buffer_full}, e);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    acc(0, 3'h0, 8'h00);
    acc(0, 3'h7, 8'h00);
    acc(1, 3'h4, 8'h07);
    send(9'h1A5, 1'b0, 8'h00);
    acc(1, 3'h0, 8'h10);
    send(9'h1A5, 1'b0, 8'h0D);
    acc(0, 3'h0, 8'h11);
    acc(0, 3'h3, 8'h01);
    acc(0, 3'h1, 8'hA5);
    acc(1, 3'h4, 8'h00);
    $display("test basic receive done");
    send(9'h033, 1'b0, 8'h09);
    send(9'h044, 1'b0, 8'hFF);
    acc(0, 3'h0, 8'h12);
    acc(0, 3'h3, 8'h05);
    acc(0, 3'h1, 8'h33);
    send(9'h055, 1'b0, 8'hFF);
    acc(0, 3'h1, 8'h33);
    acc(1, 3'h0, 8'h00);
    acc(0, 3'h0, 8'h00);
    acc(1, 3'h0, 8'h10);
    send(9'h0F0, 1'b1, 8'h09);
    acc(0, 3'h0, 8'h14);
    acc(0, 3'h3, 8'h03);
    acc(0, 3'h1, 8'hF0);
    send(9'h10F, 1'b0, 8'h09);
    acc(0, 3'h0, 8'h11);
    acc(0, 3'h1, 8'h0F);
    $display("test errors done");
    acc(1, 3'h2, 8'h04);
    acc(1, 3'h0, 8'h18);
    send(9'h0AA, 1'b0, 8'h08);
    send(9'h1BB, 1'b0, 8'h09);
    acc(1, 3'h2, 8'h00);
    acc(0, 3'h1, 8'hBB);
    send(9'h0CC, 1'b0, 8'h09);
    acc(1, 3'h2, 8'h04);
    acc(1, 3'h0, 8'h10);
    acc(0, 3'h1, 8'hCC);
    send(9'h0DD, 1'b0, 8'h09);
    acc(0, 3'h0, 8'h10);
    acc(0, 3'h1, 8'hDD);
    $display("test address detect done");
    acc(1, 3'h2, 8'h03);
    acc(1, 3'h0, 8'h20);
    acc(0, 3'h0, 8'h20);
    chk("single", {7'h00, single_active}, 8'h01);
    send(9'h1EE, 1'b0, 8'h01);
    acc(0, 3'h0, 8'h01);
    acc(0, 3'h1, 8'hEE);
    // With both controls clear the master must not receive at all
    send(9'h0AB, 1'b0, 8'h00);
    acc(1, 3'h0, 8'h30);
    send(9'h011, 1'b0, 8'h09);
    acc(1, 3'h2, 8'h01);
    acc(1, 3'h0, 8'h20);
    send(9'h022, 1'b0, 8'h01);
    $display("test synchronous done");
    results();
  end
endmodule // serial_receive_control_status_bench
`default_nettype wire
